// ==== smga_pkg.sv ====
`default_nettype none
package smga_pkg;
  // register byte offsets inside the slave window
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFS_CR0  = 8'h00;
  localparam logic [7:0] OFS_ACR  = 8'h04;
  localparam logic [7:0] OFS_SACR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // global_control_low fields
  localparam int unsigned B_BYPASS   = 0;
  localparam int unsigned B_GF_ABORT = 1;
  localparam int unsigned B_GF_IRQ   = 2;
  localparam int unsigned B_CF_ABORT = 4;
  localparam int unsigned B_CF_IRQ   = 5;

  // auxiliary configuration fields
  localparam int unsigned B_PREFETCH = 0;
  localparam int unsigned B_WC1      = 1;
  localparam int unsigned B_WC2      = 2;
  localparam int unsigned B_NOMATCH  = 8;
  localparam int unsigned B_OFFCTX   = 9;
  localparam int unsigned B_S2C_TLB  = 10;
  localparam int unsigned B_NORM     = 11;

  // implemented bits of each register
  localparam logic [31:0] CR0_MASK  = 32'h0000_0037;
  localparam logic [31:0] ACR_MASK  = 32'h0000_0707;
  localparam logic [31:0] SACR_MASK = 32'h0000_0700;
  localparam logic [31:0] CR0_RST   = 32'h0000_0001;
  localparam logic [31:0] ACR_RST   = 32'h0000_0000;

  // interrupt status and mask layout
  localparam int unsigned ST_W  = 2;
  localparam int unsigned ST_GF = 0;
  localparam int unsigned ST_CF = 1;
  localparam logic [1:0]  ST_RST = 2'h0;

  // memory attribute encodings
  localparam int unsigned ATTR_W = 4;
  localparam logic [3:0] DEF_ATTR_WB = 4'hf;
  localparam logic [3:0] DEF_ATTR_NC = 4'h4;

  // bus encodings
  localparam int unsigned HTRANS_ACT = 1;
  localparam logic        HRESP_OKAY = 1'h0;
endpackage : smga_pkg
`default_nettype wire

// ==== smga_top.sv ====
// The AHB-Lite register port and the register offsets were left to the implementer.
`default_nettype none
module smga_top #(
  parameter int unsigned          ADDR_W  = 32,
  parameter logic [smga_pkg::ATTR_W-1:0] ATTR_WB = smga_pkg::DEF_ATTR_WB,
  parameter logic [smga_pkg::ATTR_W-1:0] ATTR_NC = smga_pkg::DEF_ATTR_NC
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hnonsec,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  input  wire logic                  norm_strap,
  input  wire logic                  global_fault_evt,
  input  wire logic                  cfg_fault_evt,
  output var  logic                  global_fault_abort,
  output var  logic                  cfg_fault_abort,
  output var  logic                  fault_irq,
  input  wire logic                  cl_valid,
  input  wire logic [ADDR_W-1:0]     cl_addr,
  input  wire logic [smga_pkg::ATTR_W-1:0] cl_attr,
  input  wire logic                  cl_secure,
  input  wire logic                  cl_s2c_bypass,
  output var  logic                  ds_valid,
  output var  logic [ADDR_W-1:0]     ds_addr,
  output var  logic [smga_pkg::ATTR_W-1:0] ds_attr,
  output var  logic                  ds_sys_share,
  output var  logic                  ds_translate,
  output var  logic                  ds_tlb_fill,
  output var  logic                  walk_cache_two_en,
  output var  logic                  walk_cache_one_en,
  output var  logic                  walk_prefetch_en
);

  logic [31:0]                cr0;
  logic [31:0]                acr_ns;
  logic [31:0]                acr_s;
  logic                       normalize_en;
  logic                       strap_done;
  logic [smga_pkg::ST_W-1:0]  irq_status;
  logic [smga_pkg::ST_W-1:0]  irq_mask;
  logic [smga_pkg::ST_W-1:0]  next_status;
  logic [smga_pkg::ST_W-1:0]  st_set;
  logic [smga_pkg::ST_W-1:0]  st_clr;
  logic [smga_pkg::ADR_W-1:0] dp_addr;
  logic                       dp_write;
  logic                       dp_read;
  logic                       dp_sec;
  logic                       ap_take;
  logic                       wr_cr0;
  logic                       wr_acr;
  logic                       wr_sacr;
  logic                       wr_stat;
  logic                       wr_mask;
  logic [31:0]                rd_mux;
  logic                       client_bypass;
  logic                       global_fault_irq_en;
  logic                       global_fault_abort_en;
  logic                       cfg_fault_irq_en;
  logic                       cfg_fault_abort_en;
  logic                       ctx_bypass_tlb_cache_en;
  logic                       attr_is_wb;
  logic                       norm_active;

  // named views of the control bits
  assign client_bypass         = cr0[smga_pkg::B_BYPASS];
  assign global_fault_abort_en = cr0[smga_pkg::B_GF_ABORT];
  assign global_fault_irq_en   = cr0[smga_pkg::B_GF_IRQ];
  assign cfg_fault_abort_en    = cr0[smga_pkg::B_CF_ABORT];
  assign cfg_fault_irq_en      = cr0[smga_pkg::B_CF_IRQ];

  // walk enables come from the non-secure copy only
  assign walk_prefetch_en  = acr_ns[smga_pkg::B_PREFETCH];
  assign walk_cache_one_en = acr_ns[smga_pkg::B_WC1];
  assign walk_cache_two_en = acr_ns[smga_pkg::B_WC2];

  // the cache enable follows the security state of the traffic
  assign ctx_bypass_tlb_cache_en = cl_secure ?
                                   acr_s[smga_pkg::B_S2C_TLB] :
                                   acr_ns[smga_pkg::B_S2C_TLB];

  // address phase is taken while the slave is ready
  assign ap_take = hsel & htrans[smga_pkg::HTRANS_ACT] & hready;

  // the strap stands in for the bit until the first edge has caught it
  assign norm_active = strap_done ? normalize_en : norm_strap;

  // data phase bookkeeping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr  <= '0;
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_sec   <= 1'b0;
    end else begin
      if (ap_take) begin
        dp_addr <= haddr[smga_pkg::ADR_W-1:0];
        dp_sec  <= ~hnonsec;
      end
      dp_write <= ap_take & hwrite;
      dp_read  <= ap_take & ~hwrite;
    end
  end

  // write strobes; the secure copy refuses non-secure writers
  always_comb begin
    wr_cr0  = 1'b0;
    wr_acr  = 1'b0;
    wr_sacr = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (!dp_write) begin
      wr_cr0 = 1'b0;
    end else if (dp_addr == smga_pkg::OFS_CR0) begin
      wr_cr0 = 1'b1;
    end else if (dp_addr == smga_pkg::OFS_ACR) begin
      wr_acr = 1'b1;
    end else if (dp_addr == smga_pkg::OFS_SACR) begin
      wr_sacr = dp_sec;
    end else if (dp_addr == smga_pkg::OFS_STAT) begin
      wr_stat = 1'b1;
    end else if (dp_addr == smga_pkg::OFS_MASK) begin
      wr_mask = 1'b1;
    end
  end

  // read mux; unmapped and reserved bits give zero
  always_comb begin
    rd_mux = '0;
    if (dp_addr == smga_pkg::OFS_CR0) begin
      rd_mux = cr0 & smga_pkg::CR0_MASK;
    end else if (dp_addr == smga_pkg::OFS_ACR) begin
      rd_mux = acr_ns & smga_pkg::ACR_MASK;
    end else if (dp_addr == smga_pkg::OFS_SACR && dp_sec) begin
      rd_mux = acr_s & smga_pkg::SACR_MASK;
      rd_mux[smga_pkg::B_NORM] = norm_active;
    end else if (dp_addr == smga_pkg::OFS_STAT) begin
      rd_mux[smga_pkg::ST_W-1:0] = irq_status;
    end else if (dp_addr == smga_pkg::OFS_MASK) begin
      rd_mux[smga_pkg::ST_W-1:0] = irq_mask;
    end
  end

  // reads take one wait state, writes none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= smga_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= ~(ap_take & ~hwrite);
      hresp     <= smga_pkg::HRESP_OKAY;
      if (dp_read) begin
        hrdata <= rd_mux;
      end
    end
  end

  // global control, bypass out of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr0 <= smga_pkg::CR0_RST;
    end else if (wr_cr0) begin
      cr0 <= hwdata & smga_pkg::CR0_MASK;
    end
  end

  // non-secure aux copy: bits 0-2 and 8-10
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acr_ns <= smga_pkg::ACR_RST;
    end else if (wr_acr) begin
      acr_ns <= hwdata & smga_pkg::ACR_MASK;
    end
  end

  // secure aux copy: bits 8-10
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acr_s <= smga_pkg::ACR_RST;
    end else if (wr_sacr) begin
      acr_s <= hwdata & smga_pkg::SACR_MASK;
    end
  end

  // normalization bit: strap caught at the first edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      normalize_en <= 1'b0;
      strap_done   <= 1'b0;
    end else if (!strap_done) begin
      normalize_en <= norm_strap;
      strap_done   <= 1'b1;
    end else if (wr_sacr) begin
      normalize_en <= hwdata[smga_pkg::B_NORM];
    end
  end

  // sticky fault status, gated by the interrupt enables
  always_comb begin
    st_set = '0;
    st_clr = '0;
    st_set[smga_pkg::ST_GF] = global_fault_evt & global_fault_irq_en;
    st_set[smga_pkg::ST_CF] = cfg_fault_evt & cfg_fault_irq_en;
    if (wr_stat) begin
      st_clr = hwdata[smga_pkg::ST_W-1:0];
    end
    next_status = st_set | (irq_status & ~st_clr); // set beats clear
  end

  // sticky status register, cleared by writing ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= smga_pkg::ST_RST;
    end else begin
      irq_status <= next_status;
    end
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= smga_pkg::ST_RST;
    end else if (wr_mask) begin
      irq_mask <= hwdata[smga_pkg::ST_W-1:0];
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= |(irq_status & irq_mask);
    end
  end

  // abort pulses back to the offending transaction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_fault_abort <= 1'b0;
      cfg_fault_abort    <= 1'b0;
    end else begin
      global_fault_abort <= global_fault_evt & global_fault_abort_en;
      cfg_fault_abort    <= cfg_fault_evt & cfg_fault_abort_en;
    end
  end

  // inner and outer write-back is left alone by normalization
  assign attr_is_wb = (cl_attr == ATTR_WB);

  // client to downstream stage, one register deep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_valid     <= 1'b0;
      ds_addr      <= '0;
      ds_attr      <= '0;
      ds_sys_share <= 1'b0;
      ds_translate <= 1'b0;
      ds_tlb_fill  <= 1'b0;
    end else begin
      ds_valid     <= cl_valid;
      ds_addr      <= cl_addr;
      ds_translate <= cl_valid & ~client_bypass;
      ds_tlb_fill  <= cl_valid & cl_s2c_bypass &
                      ctx_bypass_tlb_cache_en;
      if (norm_active && !attr_is_wb) begin
        ds_attr      <= ATTR_NC;
        ds_sys_share <= 1'b1;
      end else begin
        ds_attr      <= cl_attr;
        ds_sys_share <= 1'b0;
      end
    end
  end

endmodule : smga_top
`default_nettype wire

// ==== smga_properties.sv ====
`default_nettype none
module smga_properties #(
  parameter logic [3:0] ATTR_WB = 4'hf,
  parameter logic [3:0] ATTR_NC = 4'h4
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       global_fault_evt,
  input wire logic       cfg_fault_evt,
  input wire logic       global_fault_abort,
  input wire logic       cfg_fault_abort,
  input wire logic       cl_valid,
  input wire logic [3:0] cl_attr,
  input wire logic       cl_s2c_bypass,
  input wire logic       ds_valid,
  input wire logic [3:0] ds_attr,
  input wire logic       ds_sys_share,
  input wire logic       ds_translate,
  input wire logic       ds_tlb_fill
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  resp_always_okay_a: assert property (hresp == smga_pkg::HRESP_OKAY)
    else $error("bus response not okay");
  read_one_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  gf_abort_cause_a: assert property (global_fault_abort
    |-> $past(global_fault_evt)) else $error("abort without global fault");
  cf_abort_cause_a: assert property (cfg_fault_abort
    |-> $past(cfg_fault_evt)) else $error("abort without config fault");
  translate_valid_a: assert property (ds_translate |-> ds_valid)
    else $error("translate mark without transaction");
  norm_attr_a: assert property (ds_sys_share
    |-> ds_attr == ATTR_NC && $past(cl_attr) != ATTR_WB)
    else $error("normalized attribute wrong");
  wb_kept_a: assert property (ds_valid && $past(cl_attr) == ATTR_WB
    |-> ds_attr == ATTR_WB && !ds_sys_share) else $error("write-back altered");
  tlb_fill_cause_a: assert property (ds_tlb_fill
    |-> $past(cl_valid && cl_s2c_bypass)) else $error("tlb fill uncaused");
endmodule : smga_properties
`default_nettype wire

// ==== smga_client.sv ====
`default_nettype none
// client master model: one transaction per call, no stall downstream
module smga_client (
  input  wire logic        hclk,
  output var  logic        cl_valid,
  output var  logic [31:0] cl_addr,
  output var  logic [3:0]  cl_attr,
  output var  logic        cl_secure,
  output var  logic        cl_s2c_bypass
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sent_addr; // address of the last beat sent
  initial begin
    sent_addr = 32'h0;
    cl_valid = 1'b0;
    cl_addr = 32'h0;
    cl_attr = 4'h0;
    cl_secure = 1'b0;
    cl_s2c_bypass = 1'b0;
  end
  // drive one beat, then scramble the idle lines
  task automatic send(input logic [3:0] a, input logic s, b);
    cl_valid <= 1'b1;
    cl_attr <= a;
    cl_secure <= s;
    cl_s2c_bypass <= b;
    sent_addr = cl_addr + 32'h1000;
    cl_addr <= sent_addr;
    @(posedge hclk);
    cl_valid <= 1'b0;
    cl_attr <= ~a;
    cl_secure <= ~s;
    cl_s2c_bypass <= ~b;
    cl_addr <= ~cl_addr;
  endtask : send
endmodule : smga_client
`default_nettype wire

// ==== tb_smga_top.sv ====
`default_nettype none
module tb_smga_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hnonsec, norm_strap;
  logic        global_fault_evt, cfg_fault_evt, hreadyout, hresp;
  logic        global_fault_abort, cfg_fault_abort, fault_irq;
  logic [31:0] haddr, hwdata, hrdata, cl_addr, ds_addr;
  logic [1:0]  htrans;
  logic [3:0]  cl_attr, ds_attr;
  logic [2:0]  wc;
  logic        cl_valid, cl_secure, cl_s2c_bypass, ds_valid;
  logic        ds_sys_share, ds_translate, ds_tlb_fill;
  int          miscompares, check_count;

  smga_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hnonsec, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .norm_strap, .global_fault_evt, .cfg_fault_evt,
    .global_fault_abort, .cfg_fault_abort, .fault_irq, .cl_valid, .cl_addr,
    .cl_attr, .cl_secure, .cl_s2c_bypass, .ds_valid, .ds_addr, .ds_attr,
    .ds_sys_share, .ds_translate, .ds_tlb_fill, .walk_cache_two_en(wc[2]),
    .walk_cache_one_en(wc[1]), .walk_prefetch_en(wc[0]));
  smga_client cl_u (.hclk, .cl_valid, .cl_addr, .cl_attr, .cl_secure,
    .cl_s2c_bypass);

  always #20 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one ahb-lite single transfer, waits on hready in both phases
  task automatic bus(input logic [7:0] a, input logic w, ns,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hnonsec <= ns;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ns = 1'b1);
    logic [31:0] q;
    bus(a, 1'b1, ns, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic ns = 1'b1);
    logic [31:0] q;
    bus(a, 1'b0, ns, 32'h0, q);
    chk(q, e);
  endtask : rc
  // pulse one fault, check abort then interrupt
  task automatic fault(input logic g, input logic [1:0] e);
    global_fault_evt <= g;
    cfg_fault_evt <= !g;
    @(posedge hclk);
    global_fault_evt <= 1'b0;
    cfg_fault_evt <= 1'b0;
    @(posedge hclk);
    chk(g ? global_fault_abort : cfg_fault_abort, e[0]);
    @(posedge hclk);
    chk(fault_irq, e[1]);
  endtask : fault
  // downstream beat is looked at on the edge after it was launched
  task automatic ds_chk(input logic [7:0] e);
    @(posedge hclk);
    chk({ds_valid, ds_translate, ds_tlb_fill, ds_sys_share, ds_attr}, e);
    chk(ds_addr, cl_u.sent_addr);
  endtask : ds_chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #100000 miscompares++;
    finish_test;
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, global_fault_evt, cfg_fault_evt} = '0;
    {haddr, hwdata, htrans} = '0;
    hnonsec = 1'b1;
    norm_strap = 1'b1; // strap from integrator
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h00, 32'h1);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h800, 1'b0);
    rc(8'h0c, 32'h0);
    rc(8'h14, 32'h0);
    $display("test reset_values done");
    wr(8'h00, '1);
    rc(8'h00, 32'h37);
    wr(8'h04, '1);
    rc(8'h04, 32'h707);
    chk(wc, 32'h7);
    wr(8'h08, 32'h400, 1'b0); // secure write: normalize cleared, tlb cache bit set
    wr(8'h08, '1);
    rc(8'h08, 32'h0);
    rc(8'h08, 32'h400, 1'b0);
    wr(8'h04, 32'h7);
    rc(8'h04, 32'h7);
    $display("test banking done");
    wr(8'h10, 32'h3);
    fault(1'b1, 2'h3);
    fault(1'b0, 2'h3);
    wr(8'h10, 32'h0);
    rc(8'h0c, 32'h3);
    chk(fault_irq, 32'h0);
    wr(8'h0c, 32'h3);
    rc(8'h0c, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h3);
    fault(1'b1, 2'h0);
    fault(1'b0, 2'h0);
    rc(8'h0c, 32'h0);
    $display("test faults done");
    cl_u.send(4'h3, 1'b1, 1'b1);
    ds_chk(8'ha3);
    cl_u.send(4'h3, 1'b0, 1'b1);
    ds_chk(8'h83);
    wr(8'h00, 32'h0);
    cl_u.send(4'h3, 1'b1, 1'b0);
    ds_chk(8'hc3);
    wr(8'h08, 32'hc00, 1'b0); // client idle meanwhile
    cl_u.send(4'h3, 1'b1, 1'b0);
    ds_chk(8'hd4);
    cl_u.send(4'hf, 1'b1, 1'b1);
    ds_chk(8'hef);
    $display("test client_path done");
    norm_strap <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h08, 32'h0, 1'b0);
    $display("test strap_low done");
    finish_test;
  end
endmodule : tb_smga_top

bind smga_top smga_properties #(.ATTR_WB(ATTR_WB), .ATTR_NC(ATTR_NC))
  prop_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .global_fault_evt, .cfg_fault_evt, .global_fault_abort,
    .cfg_fault_abort, .cl_valid, .cl_attr, .cl_s2c_bypass, .ds_valid,
    .ds_attr, .ds_sys_share, .ds_translate, .ds_tlb_fill);
`default_nettype wire
